/* dram_regs_pkg.sv */
/*
 * Shared constants and types for the DRAM control-register bank and
 * refresh logic: serial register addresses, field positions, reset values,
 * self-refresh timing and the row-packet command set.
 * Assumes a single 50 MHz core clock shared with the request decoder.
 */
package dram_regs_pkg;
    // Serial register addresses
    localparam logic [7:0] ADDR_IDENT       = 8'h00;
    localparam logic [7:0] ADDR_CONFIG      = 8'h01;
    localparam logic [7:0] ADDR_POWER       = 8'h03;
    localparam logic [7:0] ADDR_SERIAL_WRITE_DATA_LOAD        = 8'h04;
    localparam logic [7:0] ADDR_REF_BANK    = 8'h07;
    localparam logic [7:0] ADDR_REF_HIGH    = 8'h08;
    localparam logic [7:0] ADDR_REF_MID     = 8'h09;
    localparam logic [7:0] ADDR_REF_LOW     = 8'h0A;
    localparam logic [7:0] ADDR_CUR_EVEN    = 8'h0C;
    localparam logic [7:0] ADDR_CUR_ODD     = 8'h0D;
    localparam logic [7:0] ADDR_TERM_EVEN   = 8'h0E;
    localparam logic [7:0] ADDR_TERM_ODD    = 8'h0F;
    localparam logic [7:0] ADDR_DELAY       = 8'h1F;
    // Field positions
    localparam int CFG_WIDTH_LSB = 0;
    localparam int CFG_SLE_BIT   = 2;
    localparam int PM_EXIT_BIT   = 0;
    localparam int PM_STATE_BIT  = 4;
    localparam int REFRESH_BANK_CONTROL_MBR_LSB  = 4;
    localparam int DLY_CWD_LSB   = 4;
    // Serial frame layout, bit index after the start field
    localparam logic [7:0] START_PATTERN = 8'h0C;
    localparam logic [4:0] BIT_SCMD_END  = 5'h01;
    localparam logic [4:0] BIT_IDENT_END = 5'h09;
    localparam logic [4:0] BIT_ADDR_END  = 5'h11;
    localparam logic [4:0] BIT_GAP       = 5'h12;
    localparam logic [4:0] BIT_DATA_END  = 5'h1A;
    localparam logic [4:0] BIT_LAST      = 5'h1B;
    // Reset values
    localparam logic [5:0]  IDENT_RESET = 6'h00;
    localparam logic [10:0] ROW_RESET   = 11'h000;
    localparam logic [1:0]  WIDTH_RESET = 2'h2;
    localparam logic [2:0]  READ_COLUMN_LATENCY_RESET  = 3'h3;
    localparam logic [2:0]  WRITE_DATA_DELAY_RESET  = 3'h2;
    // Self-refresh timing
    localparam int CLOCK_MHZ        = 50;
    localparam int SELF_REF_NS      = 7800;
    localparam int SELF_REF_CYCLES  = (SELF_REF_NS * CLOCK_MHZ) / 1000;

    typedef enum logic [2:0] {
        ROW_NOP, ROW_ACTIVATE, ROW_PRECHARGE,
        ROW_REF_ACTIVATE, ROW_REF_INCREMENT, ROW_REF_PRECHARGE
    } row_cmd_t;

    typedef struct packed {
        logic       valid;
        row_cmd_t   cmd;
        logic [2:0] bank;
        logic [10:0] row;
    } row_packet_t;

    typedef struct packed {
        logic [1:0] io_width;
        logic       serial_load_enable;
        logic [5:0] drive_current_even_value;
        logic [5:0] drive_current_odd_value;
        logic [5:0] termination_even_value;
        logic [5:0] termination_odd_value;
        logic [2:0] read_column_latency;
        logic [2:0] write_data_delay;
    } settings_t;
endpackage : dram_regs_pkg

/* dram_control_regs_refresh.sv */
/*
 * Control-register bank, serial register port and refresh engine of a
 * DRAM device. Registers are reached over the serial pins (clock, command,
 * data in, data out); row packets and power-down commands come decoded
 * from request logic on the core clock.
 * Assumes the serial pins are asynchronous and much slower than the clock.
 */
`timescale 1ns/10ps
module dram_control_regs_refresh (
    input  wire logic                       clock,          // 50 MHz core clock
    input  wire logic                       rst,            // Synchronous reset
    input  wire logic                       ser_clk,        // Serial clock pin
    input  wire logic                       ser_cmd,        // Serial command pin
    input  wire logic                       ser_din,        // Serial data in pin
    output logic                            ser_dout,       // Serial data out pin
    input  dram_regs_pkg::row_packet_t      row_pkt,        // Decoded row packet
    input  wire logic                       power_down_cmd, // Power-down from column packet
    output dram_regs_pkg::settings_t        settings,       // Live configuration
    output logic                            powered_down,   // Device in power-down
    output logic [7:0]                      bank_open,      // Per-bank sensed state
    output logic                            sense_pulse,    // Row sensed by refresh
    output logic [7:0]                      sense_banks,    // Banks being refreshed
    output logic [10:0]                     sense_row,      // Row being refreshed
    output logic                            serial_write_data_load_valid,     // Serial write data strobe
    output logic [7:0]                      serial_write_data_load_data       // Serial write data
);
    typedef enum logic {SER_HUNT, SER_FRAME} ser_state_t;
    logic [2:0]  sync1_r, sync2_r, sync3_r, filt_r;
    ser_state_t  ser_state_r;
    logic [4:0]  bit_cnt_r;
    logic [7:0]  shift_r, rd_shift_r, addr_r;
    logic [1:0]  scmd_r, mbr_r;
    logic        sck_prev_r, selected_r, window_r, ser_dout_r;
    logic [5:0]  ident_r;
    dram_regs_pkg::settings_t settings_r;
    logic        exit_r, down_r, serial_write_data_load_valid_r, sense_pulse_r;
    logic [2:0]  ref_bank_r;
    logic [10:0] row_ptr_r, sense_row_r;
    logic [7:0]  bank_open_r, sense_banks_r, serial_write_data_load_r;
    logic [15:0] self_cnt_r;
    // Pin filter: a change counts once stages two and three agree
    wire  [2:0] filt_nxt = (sync2_r & sync3_r) | (filt_r & (sync2_r ^ sync3_r));
    wire        sck_fall = sck_prev_r & ~filt_r[2];
    wire        cmd_bit  = filt_r[1];
    wire  [7:0] byte_in  = {shift_r[6:0], cmd_bit};
    wire        in_frame = ser_state_r == SER_FRAME;
    wire        is_read  = scmd_r[1];
    always_ff @(posedge clock) begin
        if (rst) begin
            sync1_r    <= 3'h0;
            sync2_r    <= 3'h0;
            sync3_r    <= 3'h0;
            filt_r     <= 3'h0;
            sck_prev_r <= 1'b0;
        end else begin
            sync1_r    <= {ser_clk, ser_cmd, ser_din};
            sync2_r    <= sync1_r;
            sync3_r    <= sync2_r;
            filt_r     <= filt_nxt;
            sck_prev_r <= filt_r[2];
        end
    end
    // Frame decode, all on the falling edge of the serial clock
    wire start_seen = !in_frame && sck_fall && byte_in[3:0] == dram_regs_pkg::START_PATTERN[3:0];
    wire ident_done = in_frame && sck_fall && bit_cnt_r == dram_regs_pkg::BIT_IDENT_END;
    // Broadcast write and forced read ignore the identifier
    wire ident_hit  = byte_in[5:0] == ident_r || scmd_r[0];
    wire gap_fall   = in_frame && sck_fall && bit_cnt_r == dram_regs_pkg::BIT_GAP;
    wire data_fall  = in_frame && sck_fall && bit_cnt_r == dram_regs_pkg::BIT_DATA_END;
    wire wr_commit  = data_fall && selected_r && !is_read;
    always_ff @(posedge clock) begin
        if (rst) begin
            ser_state_r <= SER_HUNT;
            bit_cnt_r   <= 5'h00;
            shift_r     <= 8'h00;
        end else if (sck_fall) begin
            shift_r <= byte_in;
            if (start_seen) begin
                ser_state_r <= SER_FRAME;
                bit_cnt_r   <= 5'h00;
                shift_r     <= 8'h00;
            end else if (in_frame && bit_cnt_r == dram_regs_pkg::BIT_LAST) begin
                ser_state_r <= SER_HUNT;
                shift_r     <= 8'h00;
            end else begin
                bit_cnt_r <= bit_cnt_r + 5'h01;
            end
        end
    end
    always_ff @(posedge clock) begin
        if (rst) begin
            scmd_r     <= 2'h0;
            addr_r     <= 8'h00;
            selected_r <= 1'b0;
        end else if (in_frame && sck_fall) begin
            if (bit_cnt_r == dram_regs_pkg::BIT_SCMD_END)
                scmd_r <= byte_in[1:0];
            if (ident_done)
                selected_r <= ident_hit;
            if (bit_cnt_r == dram_regs_pkg::BIT_ADDR_END)
                addr_r <= byte_in;
        end
    end
    // Read mux: one address per register, unmapped and reserved bits read 0
    wire [7:0] rd_data =
        addr_r == dram_regs_pkg::ADDR_IDENT    ? {2'h0, ident_r} :
        addr_r == dram_regs_pkg::ADDR_CONFIG   ? {5'h00, settings_r.serial_load_enable,
                                                  settings_r.io_width} :
        addr_r == dram_regs_pkg::ADDR_POWER    ? {3'h0, down_r, 3'h0, exit_r} :
        addr_r == dram_regs_pkg::ADDR_SERIAL_WRITE_DATA_LOAD     ? serial_write_data_load_r :
        addr_r == dram_regs_pkg::ADDR_REF_BANK ? {2'h0, mbr_r, 1'b0, ref_bank_r} :
        addr_r == dram_regs_pkg::ADDR_REF_HIGH ? {5'h00, row_ptr_r[10:8]} :
        addr_r == dram_regs_pkg::ADDR_REF_MID  ? {4'h0, row_ptr_r[7:4]} :
        addr_r == dram_regs_pkg::ADDR_REF_LOW  ? {4'h0, row_ptr_r[3:0]} :
        addr_r == dram_regs_pkg::ADDR_CUR_EVEN ? {2'h0, settings_r.drive_current_even_value} :
        addr_r == dram_regs_pkg::ADDR_CUR_ODD  ? {2'h0, settings_r.drive_current_odd_value} :
        addr_r == dram_regs_pkg::ADDR_TERM_EVEN ? {2'h0, settings_r.termination_even_value} :
        addr_r == dram_regs_pkg::ADDR_TERM_ODD ? {2'h0, settings_r.termination_odd_value} :
        addr_r == dram_regs_pkg::ADDR_DELAY    ? {1'b0, settings_r.write_data_delay, 1'b0,
                                                  settings_r.read_column_latency} :
        8'h00;
    // In a read's data window, unselected devices pass data in straight to data out, so a chain works
    always_ff @(posedge clock) begin
        if (rst) begin
            window_r   <= 1'b0;
            rd_shift_r <= 8'h00;
            ser_dout_r <= 1'b0;
        end else if (gap_fall && is_read) begin
            window_r   <= 1'b1;
            rd_shift_r <= {rd_data[6:0], 1'b0};
            ser_dout_r <= selected_r ? rd_data[7] : filt_r[0];
        end else if (window_r && data_fall) begin
            window_r   <= 1'b0;
            ser_dout_r <= 1'b0;
        end else if (window_r && !selected_r) begin
            ser_dout_r <= filt_r[0];
        end else if (window_r && sck_fall) begin
            rd_shift_r <= {rd_shift_r[6:0], 1'b0};
            ser_dout_r <= rd_shift_r[7];
        end
    end
    function automatic logic wr_to(input logic [7:0] a);
        return wr_commit && addr_r == a;
    endfunction : wr_to
    always_ff @(posedge clock) begin
        if (rst) begin
            ident_r                            <= dram_regs_pkg::IDENT_RESET;
            settings_r                         <= '0;
            settings_r.io_width                <= dram_regs_pkg::WIDTH_RESET;
            settings_r.read_column_latency     <= dram_regs_pkg::READ_COLUMN_LATENCY_RESET;
            settings_r.write_data_delay        <= dram_regs_pkg::WRITE_DATA_DELAY_RESET;
        end else begin
            if (wr_to(dram_regs_pkg::ADDR_IDENT))
                ident_r <= byte_in[5:0];
            if (wr_to(dram_regs_pkg::ADDR_CONFIG)) begin
                settings_r.io_width <= byte_in[dram_regs_pkg::CFG_WIDTH_LSB +: 2];
                settings_r.serial_load_enable <= byte_in[dram_regs_pkg::CFG_SLE_BIT];
            end
            if (wr_to(dram_regs_pkg::ADDR_CUR_EVEN))
                settings_r.drive_current_even_value <= byte_in[5:0];
            if (wr_to(dram_regs_pkg::ADDR_CUR_ODD))
                settings_r.drive_current_odd_value <= byte_in[5:0];
            if (wr_to(dram_regs_pkg::ADDR_TERM_EVEN))
                settings_r.termination_even_value <= byte_in[5:0];
            if (wr_to(dram_regs_pkg::ADDR_TERM_ODD))
                settings_r.termination_odd_value <= byte_in[5:0];
            if (wr_to(dram_regs_pkg::ADDR_DELAY)) begin
                settings_r.read_column_latency <= byte_in[2:0];
                settings_r.write_data_delay <= byte_in[dram_regs_pkg::DLY_CWD_LSB +: 3];
            end
        end
    end
    // Serial write data reaches memory only while serial load is enabled
    always_ff @(posedge clock) begin
        if (rst) begin
            serial_write_data_load_r       <= 8'h00;
            serial_write_data_load_valid_r <= 1'b0;
        end else begin
            serial_write_data_load_valid_r <= wr_to(dram_regs_pkg::ADDR_SERIAL_WRITE_DATA_LOAD) && settings_r.serial_load_enable;
            if (wr_to(dram_regs_pkg::ADDR_SERIAL_WRITE_DATA_LOAD))
                serial_write_data_load_r <= byte_in;
        end
    end
    // Exit write placed last so it wins over a power-down in the same cycle
    wire exit_write = wr_to(dram_regs_pkg::ADDR_POWER) && byte_in[dram_regs_pkg::PM_EXIT_BIT];
    always_ff @(posedge clock) begin
        if (rst) begin
            exit_r <= 1'b1;
            down_r <= 1'b0;
        end else begin
            if (power_down_cmd) begin
                exit_r <= 1'b0;
                down_r <= 1'b1;
            end
            if (wr_to(dram_regs_pkg::ADDR_POWER))
                exit_r <= byte_in[dram_regs_pkg::PM_EXIT_BIT];
            if (exit_write)
                down_r <= 1'b0;
        end
    end
    // Refresh group: multi-bank field widens one refresh to 1, 2, 4 or 8 banks
    wire [7:0]  grp_mask = mbr_r == 2'h0 ? 8'h01 : mbr_r == 2'h1 ? 8'h03 :
                           mbr_r == 2'h2 ? 8'h0F : 8'hFF;
    wire [2:0]  pkt_base  = row_pkt.bank & ~grp_mask[3:1];
    wire [2:0]  self_base = ref_bank_r & ~grp_mask[3:1];
    wire [7:0]  pkt_group = 8'(grp_mask << pkt_base);
    wire [7:0]  self_group = 8'(grp_mask << self_base);
    wire [3:0]  self_next = {1'b0, self_base} + {1'b0, grp_mask[3:1]} + 4'h1;
    wire        ref_act   = row_pkt.valid && !bank_open_r[row_pkt.bank] &&
                            (row_pkt.cmd == dram_regs_pkg::ROW_REF_ACTIVATE ||
                             row_pkt.cmd == dram_regs_pkg::ROW_REF_INCREMENT);
    wire        ref_inc   = ref_act && row_pkt.cmd == dram_regs_pkg::ROW_REF_INCREMENT;
    wire        self_fire = down_r &&
                            self_cnt_r == 16'(dram_regs_pkg::SELF_REF_CYCLES - 1);
    wire        row_adv   = ref_inc || (self_fire && self_next[3]);
    always_ff @(posedge clock) begin
        if (rst || !down_r)
            self_cnt_r <= 16'h0000;
        else
            self_cnt_r <= self_fire ? 16'h0000 : self_cnt_r + 16'h0001;
    end
    always_ff @(posedge clock) begin
        if (rst) begin
            ref_bank_r <= 3'h0;
            mbr_r      <= 2'h0;
        end else if (wr_to(dram_regs_pkg::ADDR_REF_BANK)) begin
            ref_bank_r <= byte_in[2:0];
            mbr_r      <= byte_in[dram_regs_pkg::REFRESH_BANK_CONTROL_MBR_LSB +: 2];
        end else if (self_fire) begin
            ref_bank_r <= self_next[2:0];
        end
    end
    // A serial write to a pointer part overrides only that part of an advance in the same cycle
    always_ff @(posedge clock) begin
        if (rst)
            row_ptr_r <= dram_regs_pkg::ROW_RESET;
        else begin
            if (row_adv)
                row_ptr_r <= row_ptr_r + 11'h001;
            if (wr_to(dram_regs_pkg::ADDR_REF_HIGH))
                row_ptr_r[10:8] <= byte_in[2:0];
            if (wr_to(dram_regs_pkg::ADDR_REF_MID))
                row_ptr_r[7:4] <= byte_in[3:0];
            if (wr_to(dram_regs_pkg::ADDR_REF_LOW))
                row_ptr_r[3:0] <= byte_in[3:0];
        end
    end
    // Bank state tracks activates and precharges; a refresh to a bank that is already open is dropped
    always_ff @(posedge clock) begin
        if (rst) begin
            bank_open_r   <= 8'h00;
            sense_pulse_r <= 1'b0;
            sense_banks_r <= 8'h00;
            sense_row_r   <= 11'h000;
        end else begin
            sense_pulse_r <= ref_act || self_fire;
            if (ref_act || self_fire) begin
                sense_banks_r <= self_fire ? self_group : pkt_group;
                sense_row_r   <= row_ptr_r;
            end
            if (ref_act)
                bank_open_r <= bank_open_r | pkt_group;
            else if (row_pkt.valid && row_pkt.cmd == dram_regs_pkg::ROW_ACTIVATE)
                bank_open_r[row_pkt.bank] <= 1'b1;
            else if (row_pkt.valid && (row_pkt.cmd == dram_regs_pkg::ROW_PRECHARGE ||
                                       row_pkt.cmd == dram_regs_pkg::ROW_REF_PRECHARGE))
                bank_open_r <= bank_open_r & ~pkt_group;
        end
    end
    assign ser_dout     = ser_dout_r;
    assign settings     = settings_r;
    assign powered_down = down_r;
    assign bank_open    = bank_open_r;
    assign sense_pulse  = sense_pulse_r;
    assign sense_banks  = sense_banks_r;
    assign sense_row    = sense_row_r;
    assign serial_write_data_load_valid   = serial_write_data_load_valid_r;
    assign serial_write_data_load_data    = serial_write_data_load_r;
    chk_exit_wakes: assert property (@(posedge clock) disable iff (rst)
        exit_write |=> !powered_down && exit_r)
        else $error("exit write did not wake device");
    chk_pdn_clears_exit: assert property (@(posedge clock) disable iff (rst)
        power_down_cmd && !wr_to(dram_regs_pkg::ADDR_POWER) |=> !exit_r && powered_down)
        else $error("power-down did not clear exit field");
    chk_refresh_row_used: assert property (@(posedge clock) disable iff (rst)
        ref_act |=> sense_pulse && sense_row == $past(row_ptr_r)
                    && bank_open[$past(row_pkt.bank)])
        else $error("refresh activate did not sense pointer row");
    chk_precharge_closes: assert property (@(posedge clock) disable iff (rst)
        row_pkt.valid && row_pkt.cmd == dram_regs_pkg::ROW_REF_PRECHARGE
        |=> !bank_open[$past(row_pkt.bank)])
        else $error("refresh precharge left bank open");
    chk_increment_ptr: assert property (@(posedge clock) disable iff (rst)
        ref_inc && !wr_commit |=> row_ptr_r == 11'($past(row_ptr_r) + 11'h001))
        else $error("refresh increment did not advance pointer");
    chk_plain_ref_holds: assert property (@(posedge clock) disable iff (rst)
        ref_act && !ref_inc && !wr_commit && !self_fire |=> $stable(row_ptr_r))
        else $error("plain refresh moved the pointer");
    chk_unmatched_passes: assert property (@(posedge clock) disable iff (rst)
        window_r && !selected_r && !data_fall |=> ser_dout == $past(filt_r[0]))
        else $error("unselected device did not pass data through");
    chk_unmapped_zero: assert property (@(posedge clock) disable iff (rst)
        addr_r[7:5] != 3'h0 |-> rd_data == 8'h00)
        else $error("unmapped address read nonzero");
    chk_current_write: assert property (@(posedge clock) disable iff (rst)
        wr_to(dram_regs_pkg::ADDR_CUR_ODD)
        |=> settings.drive_current_odd_value == $past(byte_in[5:0]))
        else $error("odd drive current not written");
    chk_serial_load_gate: assert property (@(posedge clock) disable iff (rst)
        serial_write_data_load_valid |-> $past(settings_r.serial_load_enable) && serial_write_data_load_data == $past(byte_in))
        else $error("serial data strobed without enable");
endmodule : dram_control_regs_refresh

/* ctrl_model.sv */
/* Memory controller model: serial register frames and row packets.
   Assumes the core clock paces it; serial half period is 12 clocks. */
`timescale 1ns/10ps
module ctrl_model (
    input  wire logic                  clock,          // Core clock
    output logic                       ser_clk,        // Serial clock, idle low
    output logic                       ser_cmd,        // Serial command
    output logic                       ser_din,        // Serial data in
    input  wire logic                  ser_dout,       // Serial data out
    output dram_regs_pkg::row_packet_t row_pkt,        // Row packet
    output logic                       power_down_cmd  // Power-down pulse
);
    initial begin
        {ser_clk, ser_cmd, ser_din, power_down_cmd} = 4'h0;
        row_pkt = '0;
    end
    // Reads send zeros as data; reserved bits are left zero by callers
    // Mapped control registers are addressed, plus one unmapped address (8'h40), never test ones
    task automatic frame(input logic [1:0] sc, input logic [5:0] id, input logic [7:0] a,
                         input logic [7:0] wd, input logic [7:0] din, output logic [7:0] rd);
        logic [31:0] b;
        rd = 8'h00;
        b = {4'hC, sc, 2'h0, id, a, 1'b0, (sc[1] ? 8'h00 : wd), 1'b0};
        for (int i = 31; i >= 0; i--) begin
            @(negedge clock);
            ser_cmd = b[i];
            // Unused data-in slots toggle so a stale level never passes
            ser_din = (i >= 1 && i <= 8) ? din[i-1] : ~ser_din;
            ser_clk = 1'b1;
            repeat (12) @(negedge clock);
            if (i >= 1 && i <= 8) rd[i-1] = ser_dout;
            ser_clk = 1'b0;
            repeat (11) @(negedge clock);
        end
    endtask : frame
    // Packet row field is junk on purpose: refresh must ignore it
    // Runs far shorter than one refresh interval, so no row can starve
    task automatic send_row(input dram_regs_pkg::row_cmd_t c, input logic [2:0] bk);
        @(negedge clock);
        row_pkt = '{valid: 1'b1, cmd: c, bank: bk, row: 11'h555};
        @(negedge clock);
        row_pkt = '0;
        repeat (3) @(negedge clock);
    endtask : send_row
    task automatic pd_pulse();
        @(negedge clock);
        power_down_cmd = 1'b1;
        @(negedge clock);
        power_down_cmd = 1'b0;
        repeat (3) @(negedge clock);
    endtask : pd_pulse
endmodule : ctrl_model

/* dram_control_regs_refresh_bench.sv */
/* Self-checking bench for the register bank and refresh engine.
   Assumes ctrl_model paces all serial and row traffic. */
`timescale 1ns/10ps
module dram_control_regs_refresh_bench;
    logic                       clock = 1'b0;
    logic                       rst   = 1'b1;
    logic                       ser_clk, ser_cmd, ser_din, ser_dout, power_down_cmd;
    logic                       powered_down, sense_pulse, serial_write_data_load_valid;
    logic [7:0]                 bank_open, sense_banks, serial_write_data_load_data;
    logic [10:0]                sense_row;
    dram_regs_pkg::row_packet_t row_pkt;
    dram_regs_pkg::settings_t   settings;
    int failures = 0, total_checks = 0, pulses = 0, loads = 0;
    always #10 clock = ~clock;
    always @(posedge clock) begin
        if (sense_pulse === 1'b1) pulses++;
        if (serial_write_data_load_valid === 1'b1) loads++;
    end
    dram_control_regs_refresh i_dut (.clock(clock), .rst(rst), .ser_clk(ser_clk),
        .ser_cmd(ser_cmd), .ser_din(ser_din), .ser_dout(ser_dout), .row_pkt(row_pkt),
        .power_down_cmd(power_down_cmd), .settings(settings), .powered_down(powered_down),
        .bank_open(bank_open), .sense_pulse(sense_pulse), .sense_banks(sense_banks),
        .sense_row(sense_row), .serial_write_data_load_valid(serial_write_data_load_valid), .serial_write_data_load_data(serial_write_data_load_data));
    ctrl_model i_ctrl (.clock(clock), .ser_clk(ser_clk), .ser_cmd(ser_cmd),
        .ser_din(ser_din), .ser_dout(ser_dout), .row_pkt(row_pkt),
        .power_down_cmd(power_down_cmd));
    task automatic results();
        if (failures == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : results
    task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check_val
    task automatic xfer(input logic [1:0] sc, input logic [5:0] id, input logic [7:0] a,
                        input logic [7:0] d, input logic chk);
        logic [7:0] r;
        i_ctrl.frame(sc, id, a, d, 8'hA5, r);
        if (chk) check_val({8'h00, r}, {8'h00, d});
    endtask : xfer
    initial begin
        int p;
        repeat (12) @(negedge clock);
        rst = 1'b0;
        repeat (4) @(negedge clock);
        xfer(2'h3, 6'h00, dram_regs_pkg::ADDR_CONFIG, 8'h02, 1'b1);
        xfer(2'h3, 6'h00, dram_regs_pkg::ADDR_DELAY, 8'h23, 1'b1);
        xfer(2'h1, 6'h2A, dram_regs_pkg::ADDR_IDENT, 8'h05, 1'b0);
        xfer(2'h2, 6'h05, dram_regs_pkg::ADDR_IDENT, 8'h05, 1'b1);
        xfer(2'h2, 6'h06, dram_regs_pkg::ADDR_IDENT, 8'hA5, 1'b1);
        xfer(2'h0, 6'h06, dram_regs_pkg::ADDR_CUR_EVEN, 8'h3F, 1'b0);
        xfer(2'h2, 6'h05, dram_regs_pkg::ADDR_CUR_EVEN, 8'h00, 1'b1);
        xfer(2'h2, 6'h05, 8'h40, 8'h00, 1'b1);
        for (int k = 0; k < 4; k++) begin
            xfer(2'h0, 6'h05, 8'h0C + 8'(k), 8'h11 + 8'(k), 1'b0);
            xfer(2'h2, 6'h05, 8'h0C + 8'(k), 8'h11 + 8'(k), 1'b1);
        end
        check_val({4'h0, settings.drive_current_even_value, settings.termination_odd_value},
                  16'h0454);
        xfer(2'h0, 6'h05, dram_regs_pkg::ADDR_DELAY, 8'h45, 1'b0);
        check_val({10'h000, settings.read_column_latency, settings.write_data_delay},
                  16'h002C);
        xfer(2'h0, 6'h05, dram_regs_pkg::ADDR_REF_HIGH, 8'h07, 1'b0);
        xfer(2'h0, 6'h05, dram_regs_pkg::ADDR_REF_MID, 8'h0F, 1'b0);
        xfer(2'h0, 6'h05, dram_regs_pkg::ADDR_REF_LOW, 8'h0F, 1'b0);
        p = pulses;
        i_ctrl.send_row(dram_regs_pkg::ROW_REF_INCREMENT, 3'h2);
        check_val(16'(pulses - p), 16'h0001);
        check_val({sense_row, 5'h00}, {11'h7FF, 5'h00});
        check_val({bank_open, sense_banks}, 16'h0404);
        xfer(2'h2, 6'h05, dram_regs_pkg::ADDR_REF_LOW, 8'h00, 1'b1);
        xfer(2'h2, 6'h05, dram_regs_pkg::ADDR_REF_HIGH, 8'h00, 1'b1);
        i_ctrl.send_row(dram_regs_pkg::ROW_REF_ACTIVATE, 3'h2);
        check_val(16'(pulses - p), 16'h0001);
        i_ctrl.send_row(dram_regs_pkg::ROW_REF_PRECHARGE, 3'h2);
        check_val({8'h00, bank_open}, 16'h0000);
        xfer(2'h0, 6'h05, dram_regs_pkg::ADDR_REF_BANK, 8'h10, 1'b0);
        xfer(2'h2, 6'h05, dram_regs_pkg::ADDR_REF_BANK, 8'h10, 1'b1);
        i_ctrl.send_row(dram_regs_pkg::ROW_REF_ACTIVATE, 3'h4);
        check_val({bank_open, 5'h00, sense_row[2:0]}, 16'h3000);
        i_ctrl.send_row(dram_regs_pkg::ROW_ACTIVATE, 3'h1);
        check_val({8'h00, bank_open}, 16'h0032);
        i_ctrl.send_row(dram_regs_pkg::ROW_PRECHARGE, 3'h0);
        check_val({sense_banks, bank_open}, 16'h3030);
        i_ctrl.pd_pulse();
        p = pulses;
        xfer(2'h3, 6'h00, dram_regs_pkg::ADDR_POWER, 8'h10, 1'b1);
        check_val({15'h0000, powered_down}, 16'h0001);
        check_val({15'h0000, pulses > p}, 16'h0001);
        xfer(2'h1, 6'h3F, dram_regs_pkg::ADDR_POWER, 8'h01, 1'b0);
        xfer(2'h3, 6'h00, dram_regs_pkg::ADDR_POWER, 8'h01, 1'b1);
        xfer(2'h0, 6'h05, dram_regs_pkg::ADDR_CONFIG, 8'h05, 1'b0);
        xfer(2'h0, 6'h05, dram_regs_pkg::ADDR_SERIAL_WRITE_DATA_LOAD, 8'h3C, 1'b0);
        check_val({5'h00, settings.io_width, settings.serial_load_enable, serial_write_data_load_data},
                  16'h033C);
        check_val(16'(loads), 16'h0001);
        results();
    end
    initial begin
        repeat (90000) @(posedge clock);
        failures++;
        results();
    end
endmodule : dram_control_regs_refresh_bench
